// ==== include/tpr_cfg.svh ====
// Summary of operation
// - each probe channel is routed to axes independently of the others
// - one pin enabled for all axes latches A, B and C together
// - encoder zero trigger on channel one latches only its own axis
// - device codes 2Ch, 2Dh, 63h select probe inputs one, two, three
// - axis field 0h applies a pin to its home axis only
// - axis field 2h applies a pin to the B axis only
// - axis field 6h applies a pin to the B and C axes
// - axis field 7h applies a pin to the A, B and C axes
// - input filter is bypassed on every pin routed to a probe input
// - fourth input select resets to 2Ch, probe input one
// - fifth input select resets to 2Dh, probe input two
// - first three input selects reset to 22h, proximity dog input
// - probe latch position choice resets to 0
`ifndef TPR_CFG_SVH
`define TPR_CFG_SVH

// ==========================================================
// sizes
`define TPR_NPIN 5
`define TPR_NAXIS 3
`define TPR_NCHAN 3
`define TPR_CODE_W 8
`define TPR_MASK_W 3
`define TPR_ADDR_W 8
`define TPR_DATA_W 32
`define TPR_FILT_W 4

// ==========================================================
// device codes
`define TPR_CODE_ONE 8'h2c
`define TPR_CODE_TWO 8'h2d
`define TPR_CODE_THREE 8'h63
`define TPR_CODE_DOG 8'h22

// ==========================================================
// axis field values and home axes, pin4..pin0
`define TPR_AXIS_AUTO 3'h0
`define TPR_HOME_MASKS 15'h1311

// ==========================================================
// register byte offsets
`define TPR_OFS_PIN0 8'h00
`define TPR_OFS_LATCH_POS 8'h14
`define TPR_OFS_ZERO_SEL 8'h18
`define TPR_OFS_FILTER 8'h1c
`define TPR_OFS_STATUS 8'h20

// ==========================================================
// field positions
`define TPR_F_CODE_LSB 0
`define TPR_F_MASK_LSB 8
`define TPR_F_BYP_LSB 8

// ==========================================================
// reset values
`define TPR_RST_LATCH_POS 1'b0
`define TPR_RST_ZERO_SEL 3'h0
`define TPR_RST_FILTER 4'h0

`endif

// ==== include/tpr_pkg.sv ====
`include "tpr_cfg.svh"

package tpr_pkg;

  // ==========================================================
  // per pin selection
  typedef struct packed {
    logic [`TPR_MASK_W-1:0] axis_mask;
    logic [`TPR_CODE_W-1:0] dev_code;
  } tpr_pin_cfg_t;

  // ==========================================================
  // per axis probe events, one bit per channel
  typedef struct packed {
    logic [`TPR_NCHAN-1:0] level;
    logic [`TPR_NCHAN-1:0] rise;
    logic [`TPR_NCHAN-1:0] fall;
  } tpr_probe_t;

  // ==========================================================
  // register bus request
  typedef struct packed {
    logic we;
    logic re;
    logic [`TPR_ADDR_W-1:0] addr;
    logic [`TPR_DATA_W-1:0] wdata;
  } tpr_bus_req_t;

endpackage

// ==== src/tpr_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tpr_cfg.svh"

module tpr_pin_sync
  import tpr_pkg::*;
#(
  parameter int W = `TPR_NPIN
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] pin_sync
);

  // ==========================================================
  // two stage synchroniser
  logic [W-1:0] meta;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      pin_sync <= '0;
    end else begin
      meta <= pin_async;
      pin_sync <= meta;
    end
  end

endmodule // tpr_pin_sync

`default_nettype wire

// ==== src/tpr_route.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tpr_cfg.svh"

module tpr_route
  import tpr_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire tpr_bus_req_t bus_req,
  output logic [`TPR_DATA_W-1:0] bus_rdata,
  input wire logic [`TPR_NPIN-1:0] probe_pin,
  input wire logic [`TPR_NAXIS-1:0] enc_zero,
  output tpr_probe_t [`TPR_NAXIS-1:0] probe_evt,
  output logic [`TPR_NPIN-1:0] filter_bypass,
  output logic [`TPR_FILT_W-1:0] input_filter_choice,
  output logic probe_latch_position_choice
);

  localparam logic [`TPR_NPIN*`TPR_MASK_W-1:0] HOME = `TPR_HOME_MASKS;
  localparam logic [`TPR_NCHAN-1:0][`TPR_CODE_W-1:0] CODES =
    {`TPR_CODE_THREE, `TPR_CODE_TWO, `TPR_CODE_ONE};

  tpr_pin_cfg_t [`TPR_NPIN-1:0] cfg;
  logic [`TPR_NAXIS-1:0] zero_sel;
  logic [`TPR_NPIN-1:0] pin_s;
  logic [`TPR_NPIN-1:0][`TPR_NAXIS-1:0][`TPR_NCHAN-1:0] route;
  logic [`TPR_NAXIS-1:0][`TPR_NCHAN-1:0] next_level;
  logic [`TPR_NPIN-1:0] next_bypass;
  logic [`TPR_DATA_W-1:0] next_rdata;

  // ==========================================================
  // pin synchroniser
  tpr_pin_sync #(.W(`TPR_NPIN)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin_async(probe_pin),
    .pin_sync(pin_s)
  );

  // ==========================================================
  // per pin selection registers
  for (genvar p = 0; p < `TPR_NPIN; p++) begin : g_pin
    localparam logic [`TPR_CODE_W-1:0] RST_CODE =
      (p == 3) ? `TPR_CODE_ONE :
      (p == 4) ? `TPR_CODE_TWO : `TPR_CODE_DOG;
    localparam logic [`TPR_ADDR_W-1:0] OFS =
      `TPR_ADDR_W'(`TPR_OFS_PIN0 + 4 * p);

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        cfg[p].dev_code <= RST_CODE;
        cfg[p].axis_mask <= `TPR_AXIS_AUTO;
      end else if (bus_req.we && bus_req.addr == OFS) begin
        cfg[p].dev_code <= bus_req.wdata[`TPR_F_CODE_LSB +: `TPR_CODE_W];
        cfg[p].axis_mask <= bus_req.wdata[`TPR_F_MASK_LSB +: `TPR_MASK_W];
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      probe_latch_position_choice <= `TPR_RST_LATCH_POS;
    end else if (bus_req.we && bus_req.addr == `TPR_OFS_LATCH_POS) begin
      probe_latch_position_choice <= bus_req.wdata[0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      zero_sel <= `TPR_RST_ZERO_SEL;
    end else if (bus_req.we && bus_req.addr == `TPR_OFS_ZERO_SEL) begin
      zero_sel <= bus_req.wdata[`TPR_NAXIS-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      input_filter_choice <= `TPR_RST_FILTER;
    end else if (bus_req.we && bus_req.addr == `TPR_OFS_FILTER) begin
      input_filter_choice <= bus_req.wdata[`TPR_FILT_W-1:0];
    end
  end

  // ==========================================================
  // routing matrix
  always_comb begin
    logic [`TPR_MASK_W-1:0] mask;
    mask = '0;
    for (int p = 0; p < `TPR_NPIN; p++) begin
      // zero field falls back to home axis
      mask = (cfg[p].axis_mask == `TPR_AXIS_AUTO) ?
        HOME[p*`TPR_MASK_W +: `TPR_MASK_W] : cfg[p].axis_mask;
      for (int a = 0; a < `TPR_NAXIS; a++) begin
        for (int c = 0; c < `TPR_NCHAN; c++) begin
          route[p][a][c] = (cfg[p].dev_code == CODES[c]) & mask[a];
        end
      end
    end
  end

  always_comb begin
    next_level = '0;
    for (int a = 0; a < `TPR_NAXIS; a++) begin
      for (int c = 0; c < `TPR_NCHAN; c++) begin
        for (int p = 0; p < `TPR_NPIN; p++) begin
          next_level[a][c] = next_level[a][c] |
            (route[p][a][c] & pin_s[p]);
        end
      end
      // encoder zero replaces the channel one pins on its own axis only
      if (zero_sel[a]) begin
        next_level[a][0] = enc_zero[a];
      end
    end
  end

  always_comb begin
    next_bypass = '0;
    for (int p = 0; p < `TPR_NPIN; p++) begin
      next_bypass[p] = |route[p];
    end
  end

  // ==========================================================
  // probe event outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      probe_evt <= '0;
    end else begin
      for (int a = 0; a < `TPR_NAXIS; a++) begin
        probe_evt[a].level <= next_level[a];
        probe_evt[a].rise <= next_level[a] & ~probe_evt[a].level;
        probe_evt[a].fall <= ~next_level[a] & probe_evt[a].level;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      filter_bypass <= '0;
    end else begin
      filter_bypass <= next_bypass;
    end
  end

  // ==========================================================
  // register read
  always_comb begin
    next_rdata = '0;
    for (int p = 0; p < `TPR_NPIN; p++) begin
      if (bus_req.addr == `TPR_ADDR_W'(`TPR_OFS_PIN0 + 4 * p)) begin
        next_rdata[`TPR_F_CODE_LSB +: `TPR_CODE_W] = cfg[p].dev_code;
        next_rdata[`TPR_F_MASK_LSB +: `TPR_MASK_W] = cfg[p].axis_mask;
      end
    end
    case (bus_req.addr)
      `TPR_OFS_LATCH_POS: next_rdata[0] = probe_latch_position_choice;
      `TPR_OFS_ZERO_SEL: next_rdata[`TPR_NAXIS-1:0] = zero_sel;
      `TPR_OFS_FILTER: next_rdata[`TPR_FILT_W-1:0] = input_filter_choice;
      `TPR_OFS_STATUS: begin
        next_rdata[`TPR_NPIN-1:0] = pin_s;
        next_rdata[`TPR_F_BYP_LSB +: `TPR_NPIN] = filter_bypass;
      end
      default: ;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_rdata <= '0;
    end else if (bus_req.re) begin
      bus_rdata <= next_rdata;
    end else begin
      bus_rdata <= '0;
    end
  end

  // ==========================================================
  // checks
  logic fresh;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  reset_four_a: assert property (
    fresh |-> cfg[3].dev_code == 8'h2c)
    else $error("fourth select reset code wrong");
  reset_five_a: assert property (
    fresh |-> cfg[4].dev_code == 8'h2d)
    else $error("fifth select reset code wrong");
  reset_dog_a: assert property (fresh |->
    cfg[0].dev_code == 8'h22 && cfg[1].dev_code == 8'h22 &&
    cfg[2].dev_code == 8'h22 && cfg[2].axis_mask == 3'h0)
    else $error("third select reset code wrong");
  reset_latch_a: assert property (fresh |->
    probe_latch_position_choice == 1'b0)
    else $error("latch position choice not zero");
  home_axis_a: assert property (
    cfg[2].dev_code == 8'h2d && cfg[2].axis_mask == 3'h0
    |-> route[2][2][1] && !route[2][1][1] && !route[2][0][1])
    else $error("auto axis not home axis");
  b_only_a: assert property (
    cfg[0].dev_code == 8'h63 && cfg[0].axis_mask == 3'h2
    |-> route[0][1][2] && !route[0][0][2] && !route[0][2][2])
    else $error("mask 2h not b only");
  b_and_c_a: assert property (
    cfg[1].dev_code == 8'h2c && cfg[1].axis_mask == 3'h6
    |-> route[1][1][0] && route[1][2][0] && !route[1][0][0])
    else $error("mask 6h not b and c");
  all_axes_a: assert property (
    cfg[2].dev_code == 8'h2c && cfg[2].axis_mask == 3'h7
    |-> route[2][0][0] && route[2][1][0] && route[2][2][0])
    else $error("mask 7h not all axes");
  same_cycle_a: assert property (
    $rose(pin_s[2]) && route[2][0][0] && route[2][1][0] && route[2][2][0]
    && zero_sel == 3'h0 && probe_evt[0].level[0] == 1'b0
    && probe_evt[1].level[0] == 1'b0 && probe_evt[2].level[0] == 1'b0
    |=> probe_evt[0].rise[0] && probe_evt[1].rise[0]
    && probe_evt[2].rise[0])
    else $error("shared pin edge not on all axes");
  zero_own_a: assert property (
    zero_sel[0] && !zero_sel[1] && pin_s == '0
    |=> probe_evt[1].level[0] == 1'b0
    && probe_evt[0].level[0] == $past(enc_zero[0]))
    else $error("encoder zero leaked to other axis");
  bypass_a: assert property (
    cfg[3].dev_code == 8'h63 |=> filter_bypass[3])
    else $error("probe pin filter not bypassed");
  read_late_a: assert property (
    bus_req.re && bus_req.addr == 8'h00 |=>
    bus_rdata[7:0] == $past(cfg[0].dev_code))
    else $error("read data not one cycle later");

  // ==========================================================
  // further routing, filter, event and register checks
  refuse_code_a: assert property (
    !(cfg[4].dev_code inside {8'h2c, 8'h2d, 8'h63}) |-> route[4] == '0)
    else $error("unknown code routed a pin");
  two_only_a: assert property (
    cfg[1].dev_code == 8'h2d |-> (route[1][0] & 3'h5) == 3'h0
    && (route[1][1] & 3'h5) == 3'h0 && (route[1][2] & 3'h5) == 3'h0)
    else $error("code 2dh routed off channel two");
  three_only_a: assert property (
    cfg[2].dev_code == 8'h63 |-> route[2][0][1:0] == 2'h0
    && route[2][1][1:0] == 2'h0 && route[2][2][1:0] == 2'h0)
    else $error("code 63h routed off channel three");
  own_axis_a: assert property (
    cfg[0].dev_code == 8'h2c && cfg[0].axis_mask == 3'h0
    && cfg[1].dev_code == 8'h2c && cfg[1].axis_mask == 3'h0
    |-> route[0][0][0] && !route[0][1][0] && route[1][1][0]
    && !route[1][0][0])
    else $error("channel not on its own axis");
  home_extra_a: assert property (
    cfg[3].axis_mask == 3'h0 && cfg[4].axis_mask == 3'h0
    |-> route[3][1] == '0 && route[3][2] == '0 && route[4][1] == '0
    && route[4][2] == '0)
    else $error("extra pin left home axis");
  any_pin_a: assert property (
    cfg[4].dev_code == 8'h63 && cfg[4].axis_mask == 3'h7
    |-> route[4][0][2] && route[4][1][2] && route[4][2][2])
    else $error("pin four not on all axes");
  no_bypass_a: assert property (
    cfg[0].dev_code == 8'h22 |=> !filter_bypass[0])
    else $error("dog pin filter bypassed");
  pulse_once_a: assert property (
    probe_evt[1].rise[1] |=> !probe_evt[1].rise[1])
    else $error("rise pulse longer than one cycle");
  zero_off_a: assert property (
    zero_sel == 3'h0 && !enc_zero[0] && pin_s == '0
    |=> probe_evt[0].level == 3'h0)
    else $error("level set with no trigger");
  latch_write_a: assert property (
    bus_req.we && bus_req.addr == 8'h14
    |=> probe_latch_position_choice == $past(bus_req.wdata[0]))
    else $error("latch position write lost");

  one_per_axis_c: cover property (
    route[0][0][0] && route[1][1][0] && route[2][2][0]);
  three_on_b_c: cover property (
    probe_evt[1].rise == 3'h7);
  all_axes_c: cover property (
    probe_evt[0].rise[0] && probe_evt[1].rise[0] && probe_evt[2].rise[0]);
  zero_trig_c: cover property (zero_sel[0] && probe_evt[0].rise[0]);
  fall_seen_c: cover property (probe_evt[0].fall[0]);

endmodule // tpr_route

`default_nettype wire

// ==== bench/tpr_sensor.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// external switch model: pins follow the wanted levels with skew
module tpr_sensor (
  input wire logic core_clk,
  input wire logic [4:0] want,
  output logic [4:0] probe_pin
);
  initial begin
    probe_pin = '0;
    forever begin
      @(posedge core_clk);
      probe_pin <= #3 want;
    end
  end
endmodule // tpr_sensor

`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tpr_cfg.svh"

module tb
  import tpr_pkg::*;
();
  logic core_clk = 0;
  logic resetn = 0;
  tpr_bus_req_t req = '0;
  logic [31:0] rdata;
  logic [4:0] want = '0;
  logic [4:0] pins;
  logic [2:0] enc = '0;
  tpr_probe_t [2:0] evt;
  logic [4:0] byp;
  logic [3:0] filt;
  logic lpos;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] rnd = 32'h3441;
  logic [7:0] code [5];
  logic [2:0] mask [5];
  logic [2:0] zsel;

  tpr_sensor i_sensor (.core_clk(core_clk), .want(want), .probe_pin(pins));
  tpr_route i_dut (.core_clk(core_clk), .resetn(resetn), .bus_req(req),
    .bus_rdata(rdata), .probe_pin(pins), .enc_zero(enc), .probe_evt(evt),
    .filter_bypass(byp), .input_filter_choice(filt),
    .probe_latch_position_choice(lpos));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] pick(input logic [1:0] s);
    case (s)
      2'h0: return 8'h2c;
      2'h1: return 8'h2d;
      2'h2: return 8'h63;
      default: return 8'h22;
    endcase
  endfunction

  // reference routing
  task automatic model(output logic [8:0] e, output logic [4:0] b);
    int ch;
    logic [2:0] m;
    e = '0;
    b = '0;
    for (int p = 0; p < 5; p++) begin
      ch = (code[p] == 8'h2c) ? 0 : (code[p] == 8'h2d) ? 1 :
           (code[p] == 8'h63) ? 2 : -1;
      m = (mask[p] != 3'h0) ? mask[p] : (p < 3) ? 3'(1 << p) : 3'h1;
      b[p] = (ch >= 0);
      for (int a = 0; a < 3; a++) begin
        if (ch >= 0 && want[p] && m[a]) e[a * 3 + ch] = 1'b1;
      end
    end
    for (int a = 0; a < 3; a++) begin
      if (zsel[a]) e[a * 3] = enc[a];
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req.we <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge core_clk);
    req.we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    req.re <= 1'b1;
    req.addr <= a;
    @(posedge core_clk);
    req.re <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic cmp_evt(input logic [8:0] g, input logic [8:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic settle_check(input logic [8:0] e0);
    logic [8:0] e;
    logic [4:0] b;
    logic [8:0] lv;
    logic [8:0] up;
    logic [8:0] dn;
    logic [31:0] d;
    up = '0;
    dn = '0;
    repeat (6) begin
      @(posedge core_clk);
      #1;
      up = up | {evt[2].rise, evt[1].rise, evt[0].rise};
      dn = dn | {evt[2].fall, evt[1].fall, evt[0].fall};
    end
    model(e, b);
    lv = {evt[2].level, evt[1].level, evt[0].level};
    cmp_evt(lv, e);
    cmp_evt(up, e & ~e0);
    cmp_evt(dn, e0 & ~e);
    cmp_evt({4'h0, byp}, {4'h0, b});
    rd(8'h20, d);
    cmp_reg(d, {19'h0, b, 3'h0, want});
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [8:0] e0;
    logic [4:0] b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    code = '{8'h22, 8'h22, 8'h22, 8'h2c, 8'h2d};
    mask = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
    zsel = 3'h0;
    for (int p = 0; p < 5; p++) begin
      rd(8'(p * 4), d);
      cmp_reg(d, {21'h0, mask[p], code[p]});
    end
    rd(8'h14, d);
    cmp_reg(d, 32'h0);
    cmp_reg({31'h0, lpos}, 32'h0);
    rd(8'hfc, d);
    cmp_reg(d, 32'h0);
    wr(8'h14, 32'h1);
    rd(8'h14, d);
    cmp_reg(d, 32'h1);
    cmp_reg({31'h0, lpos}, 32'h1);
    rnd = lfsr(rnd);
    wr(8'h1c, rnd);
    rd(8'h1c, d);
    cmp_reg(d, {28'h0, rnd[3:0]});
    cmp_reg({28'h0, filt}, {28'h0, rnd[3:0]});
    model(e0, b0);
    settle_check(e0);
    for (int it = 0; it < 84; it++) begin
      if (it == 60) begin
        zsel = 3'h5;
        wr(8'h18, 32'h5);
        rd(8'h18, d);
        cmp_reg(d, 32'h5);
      end
      if (it < 80) begin
        for (int p = 0; p < 5; p++) begin
          rnd = lfsr(rnd);
          code[p] = pick(rnd[1:0]);
          mask[p] = rnd[4:2];
          wr(8'(p * 4), {21'h0, mask[p], code[p]});
        end
      end
      repeat (2) @(posedge core_clk);
      model(e0, b0);
      rnd = lfsr(rnd);
      want <= (it < 80) ? rnd[9:5] : 5'h0;
      enc <= rnd[12:10];
      settle_check(e0);
    end
    print_verdict();
  end
endmodule // tb

`default_nettype wire
